// *** verilog/rss_reset_sequencer.v ***
// reset source sequencer: six sources, sticky cause record, settle count,
// apb register file and cause interrupt
// assumes rst comes from a supply-level power-up detector on ref_clk,
// which here runs from the always-on internal oscillator
// assumes every input but the board pin is already synchronous to ref_clk,
// and that the settle count is scaled to the real ref_clk rate;
// a slower oscillator stretches the hold, a faster one shortens it
//
// Behaviour
// - six reset sources all drive internal reset
// - set cause bit of triggering reset source
// - cause bits survive later reset sequences
// - pin reset clears other causes, keeps pin
// - pin reset spares the test port controller
// - after pin release hold reset through settling
// - release internal reset when settling completes
// - power-on waits for later of pin, por
// - then settle with reset held, then release
// - power-on indication only at initial power-up
// - power-on also resets test port controller
// - internal oscillator clocks this sequencer
// - seven read-only identification registers
`timescale 1ns/1ps
`include "rss_consts.vh"

module rss_reset_sequencer #(
    parameter SETTLE_CYC = `RSS_SETTLE_CYC,
    parameter [31:0] ID_WORD0 = 32'h00a5_0001, // arbitrary
    parameter [31:0] ID_WORD1 = 32'h00a5_0002, // arbitrary
    parameter [31:0] ID_WORD2 = 32'h0000_0003, // arbitrary
    parameter [31:0] ID_WORD3 = 32'h0000_0004, // arbitrary
    parameter [31:0] ID_WORD4 = 32'h0000_0005, // arbitrary
    parameter [31:0] ID_WORD5 = 32'h0000_0006, // arbitrary
    parameter [31:0] ID_WORD6 = 32'h0000_0007 // arbitrary
) (
    input wire ref_clk,
    input wire rst,
    input wire ext_reset_n,
    input wire por_active,
    input wire brownout_detect,
    input wire watchdog_reset,
    input wire core_regulator_fault,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire sys_reset,
    output wire tap_reset,
    output wire cause_irq
);

    reg [31:0] prdata_r;
    reg [1:0] state_r;
    reg [31:0] cnt_r;
    reg pin_s1_r;
    reg pin_s2_r;
    reg por_seen_r;
    reg por_done_r;
    reg tap_rst_r;
    reg sys_rst_r;
    reg [`RSS_NCAUSE-1:0] cause_r;
    reg [`RSS_NCAUSE-1:0] mask_r;
    reg swrst_r;
    reg [`RSS_NCAUSE-1:0] trig;
    reg [`RSS_NCAUSE-1:0] cause_nxt;
    reg [31:0] rd_nxt;
    reg hit;
    wire pin_low;
    wire wr;
    wire rd;
    wire [31:0] id_tab [0:6];
    reg [1:0] state_nxt;
    reg [31:0] cnt_nxt;
    reg sys_rst_nxt;
    // header codes pulled into local names for the state machine
    localparam [1:0] ST_WAIT = `RSS_ST_WAIT;
    localparam [1:0] ST_SETTLE = `RSS_ST_SETTLE;
    localparam [1:0] ST_RUN = `RSS_ST_RUN;
    localparam [1:0] ST_PULSE = `RSS_ST_PULSE;
    // all seven id words side by side, word 0 lowest
    localparam [223:0] ID_ALL = {ID_WORD6, ID_WORD5, ID_WORD4, ID_WORD3,
                                 ID_WORD2, ID_WORD1, ID_WORD0};
    genvar g;

    // fixed words, read-only: writes never reach them
    generate
        for (g = 0; g < `RSS_NID; g = g + 1) begin : g_id
            assign id_tab[g] = ID_ALL[g*32 +: 32];
        end
    endgenerate

    // two-flop synchroniser on the board pin; only stage two is used
    // a metastable first stage must never cut the settle hold short
    always @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= ext_reset_n;
            pin_s2_r <= pin_s1_r;
        end
    end
    assign pin_low = ~pin_s2_r;

    // power-on indication latched once; never re-armed after first release
    always @(posedge ref_clk) begin
        if (rst) begin
            por_seen_r <= 1'b1;
            por_done_r <= 1'b0;
        end else if (!por_done_r) begin
            por_seen_r <= por_active;
            if (!por_active && !pin_low)
                por_done_r <= 1'b1;
        end else begin
            por_seen_r <= 1'b0;
        end
    end

    // a low pin only counts as a cause once power-up is over
    wire pin_trig;
    assign pin_trig = pin_low & por_done_r;

    // trigger vector, one bit per source
    always @* begin
        trig = {`RSS_NCAUSE{1'b0}};
        trig[`RSS_C_PIN] = pin_trig;
        trig[`RSS_C_POR] = por_seen_r;
        trig[`RSS_C_BOR] = brownout_detect;
        trig[`RSS_C_SW] = swrst_r;
        trig[`RSS_C_WDT] = watchdog_reset;
        trig[`RSS_C_LDO] = core_regulator_fault;
    end

    // next state; pin and power-on go through the settle count,
    // other sources give a short internal pulse
    // runs on ref_clk, the internal oscillator, not the main one
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sys_rst_nxt = sys_rst_r;
        case (state_r)
        ST_WAIT: begin
            sys_rst_nxt = 1'b1;
            cnt_nxt = 32'h0000_0000;
            // later of pin and por release
            if (!pin_low && !por_active)
                state_nxt = ST_SETTLE;
        end
        ST_SETTLE: begin
            sys_rst_nxt = 1'b1;
            if (pin_low) begin
                cnt_nxt = 32'h0000_0000;
                state_nxt = ST_WAIT;
            end else if (cnt_r >= SETTLE_CYC - 1) begin
                sys_rst_nxt = 1'b0;
                state_nxt = ST_RUN;
            end else begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end
        ST_RUN: begin
            cnt_nxt = 32'h0000_0000;
            if (pin_low) begin
                sys_rst_nxt = 1'b1;
                state_nxt = ST_WAIT;
            end else if (|trig) begin
                sys_rst_nxt = 1'b1;
                state_nxt = ST_PULSE;
            end
        end
        ST_PULSE: begin
            sys_rst_nxt = 1'b1;
            if (pin_low) begin
                state_nxt = ST_WAIT;
            end else if (cnt_r >= `RSS_PULSE_CYC - 1 && !(|trig)) begin
                sys_rst_nxt = 1'b0;
                state_nxt = ST_RUN;
            end else if (cnt_r < `RSS_PULSE_CYC - 1) begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end
        default: begin
            state_nxt = ST_WAIT;
            sys_rst_nxt = 1'b1;
        end
        endcase
    end

    // core held in reset from block power-up on
    always @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_WAIT;
            cnt_r <= 32'h0000_0000;
            sys_rst_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sys_rst_r <= sys_rst_nxt;
        end
    end

    // test port reset follows power-on only, never the pin
    // por_seen is already registered, so tap_reset lags por by two edges
    always @(posedge ref_clk) begin
        if (rst)
            tap_rst_r <= 1'b1;
        else
            tap_rst_r <= por_seen_r;
    end

    assign sys_reset = sys_rst_r;
    assign tap_reset = tap_rst_r;

    // apb slave: zero wait states
    assign wr = psel & penable & pwrite;
    // read data is loaded in the setup cycle, so rd marks that cycle
    assign rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // write strobes per register
    wire cause_wr;
    wire mask_wr;
    wire ctrl_wr;
    assign cause_wr = wr & (paddr == `RSS_OFF_CAUSE);
    assign mask_wr = wr & (paddr == `RSS_OFF_MASK);
    assign ctrl_wr = wr & (paddr == `RSS_OFF_CTRL);

    // status: por done, synchronised pin, sequencer state
    wire [31:0] status_word;
    assign status_word = {28'h0000000, por_done_r, pin_low, state_r};

    always @* begin
        hit = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
        `RSS_OFF_CAUSE: rd_nxt[`RSS_NCAUSE-1:0] = cause_r;
        `RSS_OFF_MASK: rd_nxt[`RSS_NCAUSE-1:0] = mask_r;
        `RSS_OFF_CTRL: rd_nxt[`RSS_CTL_SWRST] = swrst_r;
        `RSS_OFF_STAT: rd_nxt = status_word;
        default: begin
            if (paddr >= `RSS_OFF_ID0 && paddr <= `RSS_OFF_ID6
                    && paddr[1:0] == 2'b00)
                rd_nxt = id_tab[paddr[4:2] - `RSS_ID_BASE_IDX];
            else
                hit = 1'b0;
        end
        endcase
    end

    // cause record: set beats write-one-to-clear; pin wipes the others
    always @* begin
        cause_nxt = cause_r;
        if (cause_wr)
            cause_nxt = cause_nxt & ~pwdata[`RSS_NCAUSE-1:0];
        // only the pin wipes history, and it outranks every other source
        cause_nxt = cause_nxt | trig;
        if (trig[`RSS_C_PIN]) begin
            cause_nxt = {`RSS_NCAUSE{1'b0}};
            cause_nxt[`RSS_C_PIN] = 1'b1;
        end
    end

    // register file sits outside sys_reset so causes survive it
    always @(posedge ref_clk) begin
        if (rst)
            cause_r <= {`RSS_NCAUSE{1'b0}};
        else
            cause_r <= cause_nxt;
    end

    always @(posedge ref_clk) begin
        if (rst)
            mask_r <= {`RSS_NCAUSE{1'b0}};
        else if (mask_wr)
            mask_r <= pwdata[`RSS_NCAUSE-1:0];
    end

    // software request self-clears once the pulse has begun
    always @(posedge ref_clk) begin
        if (rst)
            swrst_r <= 1'b0;
        else if (ctrl_wr)
            swrst_r <= pwdata[`RSS_CTL_SWRST];
        else if (state_r == ST_PULSE)
            swrst_r <= 1'b0;
    end

    // loaded at setup so it stands through the access phase
    always @(posedge ref_clk) begin
        if (rst)
            prdata_r <= 32'h0000_0000;
        else if (rd)
            prdata_r <= rd_nxt;
    end

    assign prdata = prdata_r;
    assign cause_irq = |(cause_r & mask_r);

endmodule // rss_reset_sequencer

// *** verilog/rss_consts.vh ***
// constants for the reset source sequencer: register map, cause bits,
// settling time and identification word layout
// assumes a 100 MHz ref_clk and a 32-bit apb slave port
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

`define RSS_CLK_MHZ 100
// settling window is 15..30 ms; we aim at the 15 ms floor
`define RSS_SETTLE_MS 15
`define RSS_SETTLE_CYC (`RSS_SETTLE_MS * 1000 * `RSS_CLK_MHZ)

// register byte offsets
`define RSS_OFF_CAUSE 12'h000
`define RSS_OFF_MASK 12'h004
`define RSS_OFF_CTRL 12'h008
`define RSS_OFF_STAT 12'h00c
`define RSS_OFF_ID0 12'h010
`define RSS_OFF_ID6 12'h028

// cause bit positions
`define RSS_C_PIN 0
`define RSS_C_POR 1
`define RSS_C_BOR 2
`define RSS_C_SW 3
`define RSS_C_WDT 4
`define RSS_C_LDO 5
`define RSS_NCAUSE 6

// control bit positions
`define RSS_CTL_SWRST 0

// sequencer states
`define RSS_ST_WAIT 2'h0
`define RSS_ST_SETTLE 2'h1
`define RSS_ST_RUN 2'h2
`define RSS_ST_PULSE 2'h3

// length of an internal reset pulse for non-settling sources
`define RSS_PULSE_CYC 16

// identification words: count, and word index of the first one
`define RSS_NID 7
`define RSS_ID_BASE_IDX 3'h4

`endif

// *** tb/rss_checker.sv ***
// checker for the reset source sequencer ports
// bound to rss_reset_sequencer, settle count handed on by the bind
`timescale 1ns/1ps
module rss_checker #(parameter SETTLE_CYC = 50) (
    input wire ref_clk,
    input wire rst,
    input wire ext_reset_n,
    input wire por_active,
    input wire brownout_detect,
    input wire watchdog_reset,
    input wire core_regulator_fault,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire sys_reset,
    input wire tap_reset,
    input wire cause_irq
);
    logic [31:0] pin_cnt;
    logic [31:0] quiet_cnt;
    wire src = brownout_detect | watchdog_reset | core_regulator_fault;
    // quiet: nothing that could start or stretch a reset pulse
    always_ff @(posedge ref_clk) begin
        pin_cnt <= (rst | !ext_reset_n | por_active) ? 32'h0 : pin_cnt + 1;
        quiet_cnt <= (rst | !ext_reset_n | por_active | src | psel & pwrite)
            ? 32'h0 : quiet_cnt + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_pin_holds: assert property (
        !ext_reset_n [*4] |-> sys_reset)
        else $error("sys_reset low with pin held");
    a_settle_min: assert property (
        $fell(sys_reset) |-> pin_cnt >= SETTLE_CYC)
        else $error("reset released before settling");
    a_settle_max: assert property (
        quiet_cnt == SETTLE_CYC + 24 |-> !sys_reset)
        else $error("reset not released");
    a_tap_spared: assert property (
        !tap_reset && !por_active |=> !tap_reset)
        else $error("tap reset without power-on");
    a_tap_por: assert property (
        por_active [*3] |-> tap_reset)
        else $error("tap reset missing at power-on");
    a_source_reset: assert property (
        $rose(src) |-> ##[1:4] sys_reset)
        else $error("source did not reset");
    a_unmapped_err: assert property (
        psel && penable && paddr > 12'h028 |-> pslverr)
        else $error("no error on unmapped access");
    a_mask_irq: assert property (
        psel && penable && pwrite && paddr == 12'h004
        && pwdata == 32'h0 |=> !cause_irq)
        else $error("irq high with mask cleared");
    c_release: cover property ($fell(sys_reset));
    c_pin: cover property (!ext_reset_n [*4]);
    c_irq: cover property ($rose(cause_irq));
endmodule // rss_checker

bind rss_reset_sequencer rss_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

// *** tb/rss_board.sv ***
// board side: reset pin with pull-up and the power-on detector
// assumes the bench asks for pin presses through press
`timescale 1ns/1ps
module rss_board #(parameter POR_CYC = 30) (
    input wire ref_clk,
    input wire press,
    output logic ext_reset_n = 1'b0,
    output logic por_active = 1'b1
);
    logic [7:0] cnt = 8'h0;
    always @(posedge ref_clk) begin
        ext_reset_n <= !press;
        if (cnt != POR_CYC) cnt <= cnt + 1;
        // one pulse after supply rise, never again
        por_active <= cnt != POR_CYC;
    end
endmodule // rss_board

// *** tb/tb.sv ***
// bench for the reset source sequencer: power-on, sources, pin, apb
// assumes rss_board stands for the pin circuit and the power-on detector
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, rst = 1'b1, press = 1'b1;
    logic brownout_detect = 1'b0, watchdog_reset = 1'b0;
    logic core_regulator_fault = 1'b0, rerr;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rdata;
    logic [5:0] exp_cause = 6'h02;
    wire [31:0] prdata;
    wire ext_reset_n, por_active, pready, pslverr;
    wire sys_reset, tap_reset, cause_irq;
    int errors = 0, compares = 0, cyc = 0;
    rss_board i_board (.*);
    rss_reset_sequencer #(.SETTLE_CYC(50), .ID_WORD0(32'hc0de)) i_dut (.*);
    initial forever #5 ref_clk = !ref_clk;
    task conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            conclude();
        end
    end
    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdata);
    endtask
    task settle;
        int n;
        n = 0;
        repeat (4) @(posedge ref_clk);
        while (sys_reset !== 1'b0 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        chk("sys_reset", 32'h0, sys_reset);
        @(posedge ref_clk);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk("held", 32'h1, sys_reset);
        press <= 1'b0;
        settle();
        chk("tap_reset", 32'h0, tap_reset);
        rd(12'h000, 32'h2, "cause");
        chk("pready", 32'h1, pready);
        rd(12'h00c, 32'ha, "status");
        apb(1'b1, 12'h010, 32'hffff_ffff);
        rd(12'h010, 32'hc0de, "id0");
        rd(12'h028, 32'h7, "id6");
        rd(12'h100, 32'h0, "unmapped");
        chk("pslverr", 32'h1, rerr);
        $display("test power_on done");
        apb(1'b1, 12'h004, 32'h3f);
        rd(12'h004, 32'h3f, "mask");
        for (int i = 2; i < 6; i++) begin
            if (i == 3) apb(1'b1, 12'h008, 32'h1);
            else begin
                brownout_detect <= (i == 2);
                watchdog_reset <= (i == 4);
                core_regulator_fault <= (i == 5);
                repeat (3) @(posedge ref_clk);
                brownout_detect <= 1'b0;
                watchdog_reset <= 1'b0;
                core_regulator_fault <= 1'b0;
            end
            settle();
            exp_cause[i] = 1'b1;
            rd(12'h000, {26'h0, exp_cause}, "cause");
            chk("cause_irq", 32'h1, cause_irq);
        end
        rd(12'h008, 32'h0, "ctrl");
        $display("test sources done");
        press <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("tap_reset", 32'h0, tap_reset);
        chk("sys_reset", 32'h1, sys_reset);
        press <= 1'b0;
        settle();
        rd(12'h000, 32'h1, "cause");
        apb(1'b1, 12'h004, 32'h0);
        chk("masked irq", 32'h0, cause_irq);
        apb(1'b1, 12'h000, 32'h1);
        rd(12'h000, 32'h0, "cleared");
        $display("test pin done");
        conclude();
    end
endmodule // tb
